/* hdl/spcfg_mem.sv */
// Flop memory with byte-wide write/read and a whole-word read port.
// Assumes single-clock use; byte 0 of a word is its least significant byte.
`timescale 1ns/1ns
module spcfg_mem
    import spcfg_pkg::*;
#(
    parameter int WORDS = 32,
    parameter int BYTES = 8
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    spcfg_mem_if.mem bus
);
    localparam int DEPTH = WORDS * BYTES;

    logic [7:0] mem_r [DEPTH];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Byte write by index; the window contents clear at reset
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= MEM_RST;
            end
        end else if (bus.wr_en) begin
            mem_r[bus.byte_idx] <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------
    assign bus.rdata = mem_r[bus.byte_idx];

    // Gather the selected word, low byte first
    always_comb begin
        bus.word = '0;
        for (int b = 0; b < BYTES; b++) begin
            bus.word[b*8 +: 8] = mem_r[int'(bus.word_sel) * BYTES + b];
        end
    end
endmodule

/* hdl/spcfg_top.sv */
// Tail of the configuration register space: global update, profile
// select with software trigger, link frame-size control, reserved words
// and the profile and coefficient memory windows.
// Assumes the serial port engine presents single-cycle byte accesses on
// sys_clk_in; the rest of the map restores itself on restore pulse.
`timescale 1ns/1ns
module spcfg_top
    import spcfg_pkg::*;
#(
    parameter int SPEED_W = 8,
    parameter int COEF_DEPTH = COEF_WORDS
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [SPEED_W-1:0] speed_mode_out,
    output logic defaults_restore_out,
    output logic [PROF_IDX_W-1:0] profile_index_out,
    output logic [63:0] active_profile_out,
    output logic transmit_event_pulse,
    output logic link_frame_length_auto
);
    localparam int PROF_IDX_BITS = $clog2(PROF_WORDS * PROF_BYTES);
    localparam int COEF_IDX_BITS = $clog2(COEF_DEPTH);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire hit_speed = (reg_addr_in == SPEED_MODE_OFF);
    wire hit_update = (reg_addr_in == GLOBAL_UPDATE_OFF);
    wire hit_prof_sel = (reg_addr_in == PROFILE_SEL_OFF);
    wire hit_frame = (reg_addr_in == FRAME_LEN_OFF);
    wire hit_prof_mem = (reg_addr_in >= PROF_MEM_BASE)
        && (reg_addr_in <= PROF_MEM_LAST);
    wire hit_coef_mem = (reg_addr_in >= COEF_MEM_BASE)
        && (reg_addr_in <= COEF_MEM_LAST);

    wire wr_speed = reg_wr_in && hit_speed;
    wire wr_update = reg_wr_in && hit_update;
    wire wr_prof_sel = reg_wr_in && hit_prof_sel;
    wire wr_frame = reg_wr_in && hit_frame;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [SPEED_W-1:0] speed_staged_r;
    logic [SPEED_W-1:0] speed_active_r;
    logic restore_r;
    logic [PROF_IDX_W-1:0] prof_idx_r;
    logic trig_r;
    logic frame_auto_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [63:0] active_prof_r;

    // Speed mode is only staged here; the running setting moves on update
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            speed_staged_r <= SPEED_MODE_RST[SPEED_W-1:0];
        end else if (wr_speed) begin
            speed_staged_r <= reg_wdata_in[SPEED_W-1:0];
        end
    end

    // Update write, any data value, commits the staged speed mode
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            speed_active_r <= SPEED_MODE_RST[SPEED_W-1:0];
        end else if (wr_update) begin
            speed_active_r <= speed_staged_r;
        end
    end

    // One-cycle restore pulse for the analog and converter registers
    // held elsewhere; this block's own link state stays put, while its speed takes the staged value
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            restore_r <= 1'b0;
        end else begin
            restore_r <= wr_update;
        end
    end

    // Profile index takes effect on the write itself
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prof_idx_r <= PROFILE_SEL_RST[PROF_IDX_W-1:0];
        end else if (wr_prof_sel) begin
            prof_idx_r <= reg_wdata_in[PROF_IDX_W-1:0];
        end
    end

    // Trigger bit self-clears, so each write of one gives one pulse;
    // it follows the register clock, not the converter sample clock
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            trig_r <= 1'b0;
        end else begin
            trig_r <= wr_prof_sel && reg_wdata_in[SOFT_TRIG_BIT];
        end
    end

    // Link register: untouched by the update restore
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            frame_auto_r <= FRAME_AUTO_RST;
        end else if (wr_frame) begin
            frame_auto_r <= reg_wdata_in[FRAME_AUTO_BIT];
        end
    end

    // ------------------------------------------------------------
    // Memory windows
    // ------------------------------------------------------------
    spcfg_mem_if #(
        .IDX_W(PROF_IDX_BITS),
        .SEL_W(PROF_IDX_W),
        .WORD_W(64)
    ) prof_if ();

    spcfg_mem_if #(
        .IDX_W(COEF_IDX_BITS),
        .SEL_W(COEF_IDX_BITS),
        .WORD_W(8)
    ) coef_if ();

    assign prof_if.wr_en = reg_wr_in && hit_prof_mem;
    assign prof_if.byte_idx = reg_addr_in[PROF_IDX_BITS-1:0];
    assign prof_if.wdata = reg_wdata_in;
    assign prof_if.word_sel = prof_idx_r;

    // Coefficient window is byte wide, so the word port mirrors the byte
    assign coef_if.wr_en = reg_wr_in && hit_coef_mem;
    assign coef_if.byte_idx = reg_addr_in[COEF_IDX_BITS-1:0];
    assign coef_if.wdata = reg_wdata_in;
    assign coef_if.word_sel = reg_addr_in[COEF_IDX_BITS-1:0];

    spcfg_mem #(
        .WORDS(PROF_WORDS),
        .BYTES(PROF_BYTES)
    ) u_prof_mem (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .bus(prof_if.mem)
    );

    spcfg_mem #(
        .WORDS(COEF_DEPTH),
        .BYTES(1)
    ) u_coef_mem (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .bus(coef_if.mem)
    );

    // Active profile is registered so downstream sees a clean word;
    // edits to the selected entry show one cycle after the write
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_prof_r <= 64'h0;
        end else begin
            active_prof_r <= prof_if.word;
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    // Speed register reads back the staged value, not the running one;
    // unmapped addresses read zero
    wire [7:0] speed_rd = 8'(speed_staged_r);
    wire [7:0] prof_sel_rd = {3'h0, prof_idx_r};
    wire [7:0] frame_rd = {3'h0, frame_auto_r, 4'h0};
    wire [7:0] rd_mux =
        hit_speed ? speed_rd :
        hit_prof_sel ? prof_sel_rd :
        hit_frame ? frame_rd :
        (reg_addr_in == RSVD_19B_OFF) ? RSVD_19B_VAL :
        (reg_addr_in == RSVD_19D_OFF) ? RSVD_19D_VAL :
        (reg_addr_in == RSVD_19E_OFF) ? RSVD_19E_VAL :
        hit_prof_mem ? prof_if.rdata :
        hit_coef_mem ? coef_if.rdata :
        8'h00;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;
    assign speed_mode_out = speed_active_r;
    assign defaults_restore_out = restore_r;
    assign profile_index_out = prof_idx_r;
    assign active_profile_out = active_prof_r;
    assign transmit_event_pulse = trig_r;
    assign link_frame_length_auto = frame_auto_r;
endmodule

/* shared/spcfg_mem_if.sv */
// Byte-access port plus whole-word read port of one flop memory.
// Assumes the controller and the memory share one clock.
`timescale 1ns/1ns
interface spcfg_mem_if #(
    parameter int IDX_W = 8,
    parameter int SEL_W = 5,
    parameter int WORD_W = 64
);
    logic wr_en;
    logic [IDX_W-1:0] byte_idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [SEL_W-1:0] word_sel;
    logic [WORD_W-1:0] word;

    modport ctl (output wr_en, output byte_idx, output wdata,
        output word_sel, input rdata, input word);
    modport mem (input wr_en, input byte_idx, input wdata,
        input word_sel, output rdata, output word);
endinterface

/* shared/spcfg_pkg.sv */
// Package for the configuration-update and profile-select register bank.
// Assumes a byte-wide register port decoded from the serial configuration
// port, all on one clock.
package spcfg_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [12:0] SPEED_MODE_OFF = 13'h0002;
    localparam logic [12:0] GLOBAL_UPDATE_OFF = 13'h00ff;
    localparam logic [12:0] PROFILE_SEL_OFF = 13'h010c;
    localparam logic [12:0] RSVD_19B_OFF = 13'h019b;
    localparam logic [12:0] FRAME_LEN_OFF = 13'h019c;
    localparam logic [12:0] RSVD_19D_OFF = 13'h019d;
    localparam logic [12:0] RSVD_19E_OFF = 13'h019e;
    localparam logic [12:0] PROF_MEM_BASE = 13'h0f00;
    localparam logic [12:0] PROF_MEM_LAST = 13'h0fff;
    localparam logic [12:0] COEF_MEM_BASE = 13'h1000;
    localparam logic [12:0] COEF_MEM_LAST = 13'h1fff;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PROF_IDX_W = 5;
    localparam int SOFT_TRIG_BIT = 5;
    localparam int FRAME_AUTO_BIT = 4;
    localparam logic [7:0] SPEED_MODE_RST = 8'h00;
    localparam logic [7:0] PROFILE_SEL_RST = 8'h00;
    localparam logic FRAME_AUTO_RST = 1'b1;
    localparam logic [7:0] RSVD_19B_VAL = 8'h70;
    localparam logic [7:0] RSVD_19D_VAL = 8'h00;
    localparam logic [7:0] RSVD_19E_VAL = 8'h10;
    localparam logic [7:0] MEM_RST = 8'h00;

    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int PROF_WORDS = 32;
    localparam int PROF_BYTES = 8;
    localparam int COEF_WORDS = 4096;
endpackage

/* verif/spcfg_host_model.sv */
// Host side of the byte register port: single byte writes and reads.
// Assumes the bank takes a strobe on the rising clock edge.
`timescale 1ns/1ns
module spcfg_host_model
    import spcfg_pkg::*;
(
    input wire logic sys_clk_in,
    output logic wr_out,
    output logic rd_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [7:0] wdata_out
);
    // ----
    // Idle port and one access
    // ----
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = '0;
        wdata_out = '0;
    end
    // Strobe held over one taking edge; lines then inverted so nothing
    // can lean on stale values. Trigger writes are plain events only
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
        input logic [7:0] d);
        @(posedge sys_clk_in);
        wr_out <= w;
        rd_out <= !w;
        addr_out <= a;
        wdata_out <= d;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
endmodule

/* verif/spcfg_top_properties.sv */
// Checker for the update and profile-select bank, on top-level ports.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ns
module spcfg_top_properties
    import spcfg_pkg::*;
#(
    parameter int SPEED_W = 8
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic reg_wr_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [SPEED_W-1:0] speed_mode_out,
    input wire logic defaults_restore_out,
    input wire logic [PROF_IDX_W-1:0] profile_index_out,
    input wire logic transmit_event_pulse,
    input wire logic link_frame_length_auto
);
    // ----
    // Write decodes and a shadow of the staged speed
    // ----
    wire upd = reg_wr_in && reg_addr_in == GLOBAL_UPDATE_OFF;
    wire prf = reg_wr_in && reg_addr_in == PROFILE_SEL_OFF;
    wire frm = reg_wr_in && reg_addr_in == FRAME_LEN_OFF;
    wire spd = reg_wr_in && reg_addr_in == SPEED_MODE_OFF;
    logic [SPEED_W-1:0] staged_r;
    // Shadow needed because the applied value comes from an older write
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in)
            staged_r <= '0;
        else if (spd)
            staged_r <= reg_wdata_in[SPEED_W-1:0];
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    speed_held_a: assert property (!upd |=> $stable(speed_mode_out))
        else $error("speed mode moved without update");
    speed_apply_a: assert property (
        upd |=> speed_mode_out == $past(staged_r))
        else $error("update did not apply staged speed");
    restore_fire_a: assert property (upd |=> defaults_restore_out)
        else $error("no restore pulse after update");
    restore_cause_a: assert property (
        defaults_restore_out |-> $past(upd))
        else $error("restore pulse without update");
    index_load_a: assert property (
        prf |=> profile_index_out == $past(reg_wdata_in[4:0]))
        else $error("profile index not loaded");
    trig_fire_a: assert property (
        prf && reg_wdata_in[5] |=> transmit_event_pulse ##1 !transmit_event_pulse)
        else $error("trigger pulse wrong");
    trig_cause_a: assert property (
        transmit_event_pulse |-> $past(prf && reg_wdata_in[5]))
        else $error("trigger without its write");
    frame_load_a: assert property (
        frm |=> link_frame_length_auto == $past(reg_wdata_in[4]))
        else $error("frame auto bit not loaded");
    frame_kept_a: assert property (
        !frm |=> $stable(link_frame_length_auto))
        else $error("frame auto bit moved");
endmodule

/* verif/spcfg_top_tb.sv */
// Self-checking bench for the update and profile-select bank.
// Assumes the host model drives the byte port; checker bound below.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module spcfg_top_tb
    import spcfg_pkg::*;
();
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic reg_wr_in, reg_rd_in, reg_rvalid_out, defaults_restore_out;
    logic transmit_event_pulse, link_frame_length_auto;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, speed_mode_out, e, s;
    logic [4:0] profile_index_out, n;
    logic [63:0] active_profile_out, w;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int n_tests = 0;
    integer seed = 32'h11de5dda;
    localparam logic [12:0] RA [3] = '{RSVD_19B_OFF, RSVD_19D_OFF,
        RSVD_19E_OFF};
    localparam logic [7:0] RV [3] = '{RSVD_19B_VAL, RSVD_19D_VAL,
        RSVD_19E_VAL};
    initial forever #2 sys_clk_in = ~sys_clk_in;
    spcfg_top #(.COEF_DEPTH(256)) dut (.sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .speed_mode_out(speed_mode_out),
        .defaults_restore_out(defaults_restore_out),
        .profile_index_out(profile_index_out),
        .active_profile_out(active_profile_out),
        .transmit_event_pulse(transmit_event_pulse),
        .link_frame_length_auto(link_frame_length_auto));
    spcfg_host_model host (.sys_clk_in(sys_clk_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .addr_out(reg_addr_in),
        .wdata_out(reg_wdata_in));
    // ----
    // Verdict, read notes and the returned-byte watcher
    // ----
    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.access(1'b0, a, 8'h00);
    endtask
    // An empty queue yields an unknown note, so a stray byte fails
    always @(negedge sys_clk_in) begin
        if (reg_rvalid_out === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
            `CHK("read data", e, reg_rdata_out)
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        $display("Error timeout exp %0d got %0d", 0, 20000);
        finish_test();
    end
    initial begin
        repeat (12) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        @(negedge sys_clk_in);
        `CHK("frame auto", 1'b1, link_frame_length_auto)
        `CHK("index reset", 5'h00, profile_index_out)
        rd(FRAME_LEN_OFF, 8'h10);
        // Reserved words ignore writes
        for (int i = 0; i < 3; i++) begin
            host.access(1'b1, RA[i], ~RV[i]);
            rd(RA[i], RV[i]);
        end
        // Speed first, then the update, as bring-up should go
        s = 8'($random(seed));
        host.access(1'b1, SPEED_MODE_OFF, s);
        host.access(1'b1, FRAME_LEN_OFF, 8'hef);
        @(negedge sys_clk_in);
        `CHK("speed staged", 8'h00, speed_mode_out)
        `CHK("frame off", 1'b0, link_frame_length_auto)
        host.access(1'b1, GLOBAL_UPDATE_OFF, 8'($random(seed)));
        @(negedge sys_clk_in);
        `CHK("speed applied", s, speed_mode_out)
        `CHK("restore", 1'b1, defaults_restore_out)
        @(negedge sys_clk_in);
        `CHK("restore end", 1'b0, defaults_restore_out)
        `CHK("frame kept", 1'b0, link_frame_length_auto)
        rd(SPEED_MODE_OFF, s);
        rd(FRAME_LEN_OFF, 8'h00);
        // Corner entries and random ones; trigger bit alternates
        for (int j = 0; j < 4; j++) begin
            n = (j == 0) ? 5'h00 : (j == 1) ? 5'h1f : 5'($random(seed));
            w = {$random(seed), $random(seed)};
            for (int b = 0; b < 8; b++)
                host.access(1'b1, PROF_MEM_BASE + 13'({n, 3'(b)}),
                    w[8*b +: 8]);
            host.access(1'b1, PROFILE_SEL_OFF, {2'h3, j[0], n});
            @(negedge sys_clk_in);
            `CHK("index", n, profile_index_out)
            `CHK("trigger", j[0], transmit_event_pulse)
            @(negedge sys_clk_in);
            `CHK("trigger end", 1'b0, transmit_event_pulse)
            `CHK("active profile", w, active_profile_out)
            rd(PROFILE_SEL_OFF, {3'h0, n});
            rd(PROF_MEM_BASE + 13'({n, 3'h7}), w[63:56]);
        end
        s = 8'($random(seed));
        host.access(1'b1, COEF_MEM_BASE + 13'h0055, s);
        rd(COEF_MEM_BASE + 13'h0055, s);
        rd(13'h0100, 8'h00);
        repeat (3) @(posedge sys_clk_in);
        // A read that never answered leaves its note behind
        `CHK("pending reads", 0, exp_q.size())
        finish_test();
    end
endmodule
bind spcfg_top spcfg_top_properties #(.SPEED_W(SPEED_W)) u_props (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .speed_mode_out(speed_mode_out),
    .defaults_restore_out(defaults_restore_out),
    .profile_index_out(profile_index_out),
    .transmit_event_pulse(transmit_event_pulse),
    .link_frame_length_auto(link_frame_length_auto));
